// file: hdl/bfp_pkg.sv
package bfp_pkg;
  // Widths and depths of the port
  localparam int           BFP_DATA_W    = 8;
  localparam int           BFP_FIFO_D    = 8;
  localparam int           BFP_PTR_W     = 3;
  localparam int           BFP_CNT_W     = 4;
  localparam logic [3:0]   BFP_CNT_FULL  = 4'h8;
  localparam logic [3:0]   BFP_CNT_ZERO  = 4'h0;
  localparam logic [2:0]   BFP_PTR_ZERO  = 3'h0;
  localparam logic [2:0]   BFP_PTR_ONE   = 3'h1;
  localparam logic [3:0]   BFP_CNT_ONE   = 4'h1;
  localparam logic [7:0]   BFP_BYTE_ZERO = 8'h00;
  // Strobe countdown start; the host holds each strobe low this plus one cycles
  localparam logic [1:0]   BFP_STB_CYC   = 2'h3;
  localparam logic [1:0]   BFP_STB_ZERO  = 2'h0;
  localparam logic [1:0]   BFP_STB_ONE   = 2'h1;

  // Host strobe sequencer states
  typedef enum logic [3:0] {
    BFP_IDLE  = 4'b0001,
    BFP_WRLOW = 4'b0010,
    BFP_RDLOW = 4'b0100,
    BFP_GAP   = 4'b1000
  } bfp_host_e;
endpackage

// file: hdl/bfp_if.sv
`timescale 1ns/1ps
// Pins between the device and the host
interface bfp_if;
  import bfp_pkg::*;
  logic                  tx_space_n;
  logic                  rx_avail_n;
  logic                  wr_n;
  logic                  rd_n;
  logic [BFP_DATA_W-1:0] dev_data_out;
  logic                  dev_data_oe_n;
  logic [BFP_DATA_W-1:0] host_data_out;
  logic                  host_data_oe_n;
  logic [BFP_DATA_W-1:0] parallel_data_lines;

  // Resolved level of the shared data lines
  assign parallel_data_lines = !dev_data_oe_n  ? dev_data_out  :
                               !host_data_oe_n ? host_data_out : {BFP_DATA_W{1'b1}};

  modport device (
    output tx_space_n,
    output rx_avail_n,
    input  wr_n,
    input  rd_n,
    output dev_data_out,
    output dev_data_oe_n,
    input  parallel_data_lines
  );
  modport host (
    input  tx_space_n,
    input  rx_avail_n,
    output wr_n,
    output rd_n,
    output host_data_out,
    output host_data_oe_n,
    input  parallel_data_lines
  );
endinterface

// file: hdl/bfp_fifo.sv
`timescale 1ns/1ps
module bfp_fifo
  import bfp_pkg::*;
#(
  parameter int WIDTH = BFP_DATA_W,
  parameter int DEPTH = BFP_FIFO_D
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } bfp_fifo_s;
  bfp_fifo_s st;
  bfp_fifo_s next_st;
  logic      push;
  logic      pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes and flags
  assign in_ready  = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = (st.wp == PW'(DEPTH-1)) ? '0 : st.wp + PW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == PW'(DEPTH-1)) ? '0 : st.rp + PW'(1);
    end
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// file: hdl/bfp_device.sv
`timescale 1ns/1ps
// Behaviour
// - Host never writes while space flag high
// - Host writes by strobe low then high
// - Host never reads while available flag high
// - Available flag low while receive byte waits
// - Host reads by strobe low then high
// - Write strobe falling edge captures data byte
// - Read strobe low drives current byte out
// - Read strobe rising edge fetches next byte
module bfp_device
  import bfp_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  bfp_if.device                      pins,
  output logic [BFP_DATA_W-1:0]      tx_data,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  input  wire logic [BFP_DATA_W-1:0] rx_data,
  input  wire logic                  rx_valid,
  output logic                       rx_ready
);
  typedef struct packed {
    logic [1:0]            wr_sync;
    logic [1:0]            rd_sync;
    logic                  wr_prev;
    logic                  rd_prev;
    logic [1:0][BFP_DATA_W-1:0] dat_sync;
    logic                  space_n;
    logic                  avail_n;
    logic [BFP_DATA_W-1:0] drive;
    logic                  oe_n;
  } bfp_dev_s;
  bfp_dev_s st;
  bfp_dev_s next_st;
  logic     wr_fall;
  logic     rd_fall;
  logic     txf_ready;
  logic     rxf_valid;
  logic     rxf_pop;
  logic [BFP_DATA_W-1:0] rxf_data;

  ////////////////////////////////////////////////////////////////////////////
  // Buffers: host to user and user to host
  bfp_fifo #(.WIDTH(BFP_DATA_W), .DEPTH(BFP_FIFO_D)) u_txf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   (st.dat_sync[1]),
    .in_valid  (wr_fall),
    .in_ready  (txf_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );
  bfp_fifo #(.WIDTH(BFP_DATA_W), .DEPTH(BFP_FIFO_D)) u_rxf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (rxf_data),
    .out_valid (rxf_valid),
    .out_ready (rxf_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised strobes
  assign wr_fall = st.wr_prev && !st.wr_sync[1];
  assign rd_fall = st.rd_prev && !st.rd_sync[1];
  // Byte on the lines is consumed when the host ends its read
  assign rxf_pop = rxf_valid && !st.rd_prev && st.rd_sync[1];

  // Pin outputs
  assign pins.tx_space_n    = st.space_n;
  assign pins.rx_avail_n    = st.avail_n;
  assign pins.dev_data_out  = st.drive;
  assign pins.dev_data_oe_n = st.oe_n;

  // Next state
  always_comb begin
    next_st          = st;
    next_st.wr_sync  = {st.wr_sync[0], pins.wr_n};
    next_st.rd_sync  = {st.rd_sync[0], pins.rd_n};
    next_st.dat_sync = {st.dat_sync[0], pins.parallel_data_lines};
    next_st.wr_prev  = st.wr_sync[1];
    next_st.rd_prev  = st.rd_sync[1];
    // High when full, and for one cycle on every capture
    next_st.space_n  = !txf_ready || wr_fall;
    // Held high across a read so the host sees the pop
    next_st.avail_n  = !rxf_valid || rxf_pop || !st.rd_sync[1];
    if (rd_fall) begin
      next_st.drive = rxf_data;
    end
    next_st.oe_n     = st.rd_sync[1] || !rxf_valid;
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st         <= '0;
      st.wr_sync <= 2'h3;
      st.rd_sync <= 2'h3;
      st.wr_prev <= 1'b1;
      st.rd_prev <= 1'b1;
      st.space_n <= 1'b1;
      st.avail_n <= 1'b1;
      st.oe_n    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// file: hdl/bfp_host.sv
`timescale 1ns/1ps
module bfp_host
  import bfp_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  bfp_if.host                        pins,
  input  wire logic [BFP_DATA_W-1:0] wr_data,
  input  wire logic                  wr_valid,
  output logic                       wr_ready,
  output logic [BFP_DATA_W-1:0]      rd_data,
  output logic                       rd_valid
);
  typedef struct packed {
    bfp_host_e             state;
    logic [1:0]            space_sync;
    logic [1:0]            avail_sync;
    logic [1:0][BFP_DATA_W-1:0] dat_sync;
    logic [1:0]            cnt;
    logic                  wr_n;
    logic                  rd_n;
    logic [BFP_DATA_W-1:0] wdat;
    logic                  oe_n;
    logic [BFP_DATA_W-1:0] rdat;
    logic                  rvld;
    logic                  wrdy;
    logic                  rpend;
  } bfp_host_s;
  bfp_host_s st;
  bfp_host_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flops
  assign pins.wr_n           = st.wr_n;
  assign pins.rd_n           = st.rd_n;
  assign pins.host_data_out  = st.wdat;
  assign pins.host_data_oe_n = st.oe_n;
  assign wr_ready            = st.wrdy;
  assign rd_data             = st.rdat;
  assign rd_valid            = st.rvld;

  // Strobe sequencer; reads take priority over writes
  always_comb begin
    next_st            = st;
    next_st.space_sync = {st.space_sync[0], pins.tx_space_n};
    next_st.avail_sync = {st.avail_sync[0], pins.rx_avail_n};
    next_st.dat_sync   = {st.dat_sync[0], pins.parallel_data_lines};
    next_st.rvld       = 1'b0;
    next_st.wrdy       = 1'b0;
    case (st.state)
      BFP_IDLE: begin
        next_st.cnt = BFP_STB_CYC;
        if (!st.avail_sync[1]) begin
          next_st.rd_n  = 1'b0;
          next_st.state = BFP_RDLOW;
        end else if (wr_valid && !st.space_sync[1]) begin
          next_st.wdat  = wr_data;
          next_st.oe_n  = 1'b0;
          next_st.wr_n  = 1'b0;
          next_st.wrdy  = 1'b1;
          next_st.state = BFP_WRLOW;
        end
      end
      BFP_WRLOW: begin
        next_st.cnt = st.cnt - BFP_STB_ONE;
        if (st.cnt == BFP_STB_ZERO) begin
          next_st.wr_n  = 1'b1;
          next_st.oe_n  = 1'b1;
          next_st.cnt   = BFP_STB_CYC;
          next_st.state = BFP_GAP;
        end
      end
      BFP_RDLOW: begin
        next_st.cnt = st.cnt - BFP_STB_ONE;
        if (st.cnt == BFP_STB_ZERO) begin
          // Device drives late after its sync; byte is taken in the gap
          next_st.rpend = 1'b1;
          next_st.rd_n  = 1'b1;
          next_st.cnt   = BFP_STB_CYC;
          next_st.state = BFP_GAP;
        end
      end
      BFP_GAP: begin
        // Let the device flags settle through its synchronisers
        next_st.cnt = st.cnt - BFP_STB_ONE;
        if (st.cnt == BFP_STB_ZERO) begin
          // Read byte has crossed the data synchroniser by now
          if (st.rpend) begin
            next_st.rdat  = st.dat_sync[1];
            next_st.rvld  = 1'b1;
            next_st.rpend = 1'b0;
          end
          next_st.state = BFP_IDLE;
        end
      end
      default: begin
        next_st.state = BFP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st            <= '0;
      st.state      <= BFP_IDLE;
      st.space_sync <= 2'h3;
      st.avail_sync <= 2'h3;
      st.wr_n       <= 1'b1;
      st.rd_n       <= 1'b1;
      st.oe_n       <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// file: tb/bfp_props.sv
`timescale 1ns/1ps
module bfp_props
  import bfp_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire logic                  tx_space_n,
  input wire logic                  rx_avail_n,
  input wire logic                  wr_n,
  input wire logic                  rd_n,
  input wire logic                  dev_data_oe_n,
  input wire logic                  host_data_oe_n,
  input wire logic [BFP_DATA_W-1:0] parallel_data_lines
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Strobe shapes: four cycles low, then high again
  sequence wr_low;
    (!wr_n)[*4] ##1 wr_n;
  endsequence
  sequence rd_low;
    (!rd_n)[*4] ##1 rd_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////////////
  chk_wr_width : assert property ($fell(wr_n) |-> wr_low)
    else $error("write strobe width wrong");
  chk_rd_width : assert property ($fell(rd_n) |-> rd_low)
    else $error("read strobe width wrong");
  chk_one_strobe : assert property (!(!wr_n && !rd_n))
    else $error("both strobes low");
  chk_wr_data_held : assert property (
    $fell(wr_n) |=> ($stable(parallel_data_lines) && !host_data_oe_n)[*3])
    else $error("write data not held");
  chk_rd_drives : assert property ($fell(rd_n) |-> ##[1:4] !dev_data_oe_n)
    else $error("device did not drive on read");
  chk_host_quiet_rd : assert property (!rd_n |-> host_data_oe_n)
    else $error("host drives during read");
  chk_rd_released : assert property (rd_n[*6] |-> dev_data_oe_n)
    else $error("device holds lines after read");
  chk_no_fight : assert property (!(!dev_data_oe_n && !host_data_oe_n))
    else $error("both ends drive data lines");
  chk_avail_held : assert property ($fell(rd_n) |-> ##5 rx_avail_n)
    else $error("avail flag low during fetch");
  chk_wr_space_low : assert property ($fell(wr_n) |-> !tx_space_n)
    else $error("write while space flag high");
  chk_rd_avail_low : assert property ($fell(rd_n) |-> !rx_avail_n)
    else $error("read while avail flag high");
endmodule

// file: tb/byte_fifo_host_port_tb.sv
`timescale 1ns/1ps
module byte_fifo_host_port_tb;
  import bfp_pkg::*;
  logic                  sys_clk;
  logic                  reset;
  logic [BFP_DATA_W-1:0] tx_data;
  logic                  tx_valid;
  logic                  tx_ready;
  logic [BFP_DATA_W-1:0] rx_data;
  logic                  rx_valid;
  logic                  rx_ready;
  logic [BFP_DATA_W-1:0] wr_data;
  logic                  wr_valid;
  logic                  wr_ready;
  logic [BFP_DATA_W-1:0] rd_data;
  logic                  rd_valid;
  logic                  saw_full;
  logic [7:0]            tq[$];
  logic [7:0]            rq[$];
  int                    wk;
  int                    cyc;
  int                    error_cnt;
  int                    n_compared;

  bfp_if pins ();
  bfp_device u_bfp_device (.sys_clk(sys_clk), .reset(reset), .pins(pins), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready));
  bfp_host u_bfp_host (.sys_clk(sys_clk), .reset(reset), .pins(pins), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid));
  bfp_props u_bfp_props (.sys_clk(sys_clk), .reset(reset), .tx_space_n(pins.tx_space_n),
    .rx_avail_n(pins.rx_avail_n), .wr_n(pins.wr_n), .rd_n(pins.rd_n),
    .dev_data_oe_n(pins.dev_data_oe_n), .host_data_oe_n(pins.host_data_oe_n),
    .parallel_data_lines(pins.parallel_data_lines));

  ////////////////////////////////////////////////////////////////////////////////////////
  // Compare helpers
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp, string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp, string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Host writes, advancing data on each taken byte, up to ten bytes
  task automatic pump(int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      if (wr_ready) wk++;
      wr_data = 8'(8'hA0 + wk);
      wr_valid = (wk < 10);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_bit(pins.tx_space_n, 1'b1, "space in reset");
    chk_bit(pins.dev_data_oe_n, 1'b1, "oe in reset");
    reset = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk_bit(pins.tx_space_n, 1'b0, "space when empty");
    chk_bit(pins.rx_avail_n, 1'b1, "avail when empty");
    $display("test_reset done");
  endtask

  task automatic test_write_fill();
    wk = 0;
    tq.delete();
    tx_ready = 1'b0;
    pump(300);
    chk_byte(8'(wk), 8'h08, "bytes taken while stalled");
    chk_bit(pins.tx_space_n, 1'b1, "space when full");
    tx_ready = 1'b1;
    pump(300);
    chk_byte(8'(tq.size()), 8'h0A, "bytes delivered");
    for (int i = 0; i < tq.size(); i++) chk_byte(tq[i], 8'(8'hA0 + i), "tx byte");
    chk_bit(pins.tx_space_n, 1'b0, "space after drain");
    $display("test_write_fill done");
  endtask

  task automatic test_read_burst();
    rq.delete();
    saw_full = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rx_data = 8'(8'h51 + i);
      rx_valid = 1'b1;
      // Ready looked at on the falling edge, where it has settled
      while (!rx_ready) begin
        saw_full = 1'b1;
        @(negedge sys_clk);
      end
      @(negedge sys_clk);
    end
    rx_valid = 1'b0;
    repeat (200) @(negedge sys_clk);
    chk_bit(saw_full, 1'b1, "receive buffer refused");
    chk_byte(8'(rq.size()), 8'h09, "bytes read");
    for (int i = 0; i < rq.size(); i++) chk_byte(rq[i], 8'(8'h51 + i), "rx byte");
    chk_bit(pins.rx_avail_n, 1'b1, "avail after drain");
    $display("test_read_burst done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Bytes leaving both user sides
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) tq.push_back(tx_data);
    if (rd_valid) rq.push_back(rd_data);
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    cyc = 0;
    error_cnt = 0;
    n_compared = 0;
    tx_ready = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    wr_data = 8'h00;
    wr_valid = 1'b0;
    test_reset();
    test_write_fill();
    test_read_burst();
    tally_and_finish();
  end
endmodule
